// ---- include/fsp_pkg.sv ----
package fsp_pkg;

    // Command opcodes
    localparam logic [7:0] FSP_WRITE_ENABLE_CMD   = 8'h3A;
    localparam logic [7:0] FSP_ENTER_SECURE_CMD   = 8'h5C;
    localparam logic [7:0] FSP_EXIT_SECURE_CMD    = 8'h6D;
    localparam logic [7:0] FSP_READ_SECURITY_CMD  = 8'h4E;
    localparam logic [7:0] FSP_WRITE_SECURITY_CMD = 8'h7B;
    localparam logic [7:0] FSP_SCHEME_SELECT_CMD  = 8'h8C;

    // Command lengths in link clocks
    localparam logic [4:0] FSP_SPI_CMD_CLOCKS  = 5'h08;
    localparam logic [4:0] FSP_QPI_CMD_CLOCKS  = 5'h02;
    localparam logic [4:0] FSP_SPI_BYTE_CLOCKS = 5'h08;
    localparam logic [4:0] FSP_QPI_BYTE_CLOCKS = 5'h02;
    localparam logic [4:0] FSP_EDGE_CNT_MAX    = 5'h1F;

    // Security status register fields
    localparam int FSP_SEC_SCHEME_BIT     = 7;
    localparam int FSP_SEC_ERASE_FAIL_BIT = 6;
    localparam int FSP_SEC_PROG_FAIL_BIT  = 5;
    localparam int FSP_SEC_RESERVED_BIT   = 4;
    localparam int FSP_SEC_ERASE_SUSP_BIT = 3;
    localparam int FSP_SEC_PROG_SUSP_BIT  = 2;
    localparam int FSP_SEC_LOCKDOWN_BIT   = 1;
    localparam int FSP_SEC_FACTORY_BIT    = 0;
    localparam logic [7:0] FSP_SEC_RESET  = 8'h00;

    // Serial output lanes
    localparam logic [2:0] FSP_SPI_FIRST_POS  = 3'h7;
    localparam logic [2:0] FSP_QPI_FIRST_POS  = 3'h7;
    localparam logic [2:0] FSP_QPI_POS_TOGGLE = 3'h4;
    localparam logic [3:0] FSP_SPI_OUT_OE     = 4'h2;
    localparam logic [3:0] FSP_SPI_IN_OE      = 4'h1;
    localparam logic [3:0] FSP_QPI_OE         = 4'hF;

    // Array layout
    localparam int FSP_ADDR_W        = 27;
    localparam int FSP_REGION_W      = 12;
    localparam int FSP_BLOCK_LSB     = 16;
    localparam int FSP_SECTOR_LSB    = 12;
    localparam int FSP_SECTORS_EDGE  = 16;

    // Link timing
    localparam int FSP_CLOCK_PERIOD_NS  = 10;
    localparam int FSP_LINK_PERIOD_NS   = 80;
    localparam int FSP_LINK_HALF_CYCLES = FSP_LINK_PERIOD_NS / FSP_CLOCK_PERIOD_NS / 2;

endpackage : fsp_pkg

// ---- include/fsp_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface fsp_link_if;
    logic       cs_n;
    logic       sclk;
    logic [3:0] host_io_out;
    logic [3:0] host_io_oe;
    logic [3:0] dev_io_out;
    logic [3:0] dev_io_oe;
    logic [3:0] io;

    // Resolved line level, pulled high when nobody drives
    genvar i;
    for (i = 0; i < 4; i++) begin : g_line
        assign io[i] = host_io_oe[i] ? host_io_out[i] :
                       dev_io_oe[i]  ? dev_io_out[i]  : 1'b1;
    end

    modport host (
        output cs_n,
        output sclk,
        output host_io_out,
        output host_io_oe,
        input  io
    );

    modport dev (
        input  cs_n,
        input  sclk,
        input  io,
        output dev_io_out,
        output dev_io_oe
    );
endinterface : fsp_link_if

`default_nettype wire

// ---- verilog/fsp_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module fsp_host
    import fsp_pkg::*;
#(
    parameter int HALF_CYCLES = FSP_LINK_HALF_CYCLES
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // Link
    fsp_link_if.host        link,
    // Command request
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_opcode,
    input  wire logic       cmd_qpi,
    input  wire logic       cmd_read,
    input  wire logic [3:0] cmd_extra_clocks,
    output logic            cmd_ready,
    // Answer
    output logic            rsp_valid,
    output logic [7:0]      rsp_data
);

    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_SETUP = 3'b001,
        HS_LOW   = 3'b010,
        HS_HIGH  = 3'b011,
        HS_HOLD  = 3'b100,
        HS_GAP   = 3'b101
    } fsp_host_state_type;

    fsp_host_state_type state;
    logic [7:0]         div_cnt;
    logic               div_end;
    logic [4:0]         clk_no;
    logic [4:0]         total;
    logic [4:0]         op_len;
    logic               qpi;
    logic               rd;
    logic [7:0]         tx;
    logic [7:0]         rx;
    logic [3:0]         io_s1;
    logic [3:0]         io_s2;

    assign div_end   = (div_cnt == 8'(HALF_CYCLES - 1));
    assign cmd_ready = (state == HS_IDLE);
    assign op_len    = qpi ? FSP_QPI_CMD_CLOCKS : FSP_SPI_CMD_CLOCKS;

    // Two-flop capture of the shared lines
    always_ff @(posedge clock) begin
        io_s1 <= link.io;
        io_s2 <= io_s1;
    end

    // Half-period divider
    always_ff @(posedge clock) begin
        if (reset || state == HS_IDLE || div_end) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // Frame sequencing
    always_ff @(posedge clock) begin
        if (reset) begin
            state  <= HS_IDLE;
            clk_no <= 5'h00;
        end else begin
            unique case (state)
                HS_IDLE: begin
                    clk_no <= 5'h00;
                    if (cmd_valid) begin
                        state <= HS_SETUP;
                    end
                end
                HS_SETUP: if (div_end) begin
                    state <= HS_HIGH;
                end
                HS_LOW: if (div_end) begin
                    state <= HS_HIGH;
                end
                HS_HIGH: if (div_end) begin
                    clk_no <= clk_no + 5'h01;
                    state  <= (clk_no + 5'h01 == total) ? HS_HOLD : HS_LOW;
                end
                HS_HOLD: if (div_end) begin
                    state <= HS_GAP;
                end
                HS_GAP: if (div_end) begin
                    state <= HS_IDLE;
                end
            endcase
        end
    end

    // Request capture
    always_ff @(posedge clock) begin
        if (reset) begin
            qpi   <= 1'b0;
            rd    <= 1'b0;
            total <= FSP_SPI_CMD_CLOCKS;
        end else if (state == HS_IDLE && cmd_valid) begin
            qpi   <= cmd_qpi;
            rd    <= cmd_read;
            total <= (cmd_qpi ? FSP_QPI_CMD_CLOCKS : FSP_SPI_CMD_CLOCKS)
                   + (cmd_read ? (cmd_qpi ? FSP_QPI_BYTE_CLOCKS : FSP_SPI_BYTE_CLOCKS)
                               : {1'b0, cmd_extra_clocks});
        end
    end

    // Pins: select low, opcode set up while clock is low
    always_ff @(posedge clock) begin
        if (reset) begin
            link.cs_n        <= 1'b1;
            link.sclk        <= 1'b0;
            link.host_io_out <= 4'h0;
            link.host_io_oe  <= 4'h0;
            tx               <= 8'h00;
        end else begin
            unique case (state)
                HS_IDLE: if (cmd_valid) begin
                    link.cs_n        <= 1'b0;
                    link.host_io_out <= cmd_qpi ? cmd_opcode[7:4] : {3'b000, cmd_opcode[7]};
                    link.host_io_oe  <= cmd_qpi ? FSP_QPI_OE : FSP_SPI_IN_OE;
                    tx               <= cmd_qpi ? {cmd_opcode[3:0], 4'h0}
                                                : {cmd_opcode[6:0], 1'b0};
                end
                HS_SETUP, HS_LOW: if (div_end) begin
                    link.sclk <= 1'b1;
                end
                HS_HIGH: if (div_end) begin
                    link.sclk        <= 1'b0;
                    link.host_io_out <= qpi ? tx[7:4] : {3'b000, tx[7]};
                    tx               <= qpi ? {tx[3:0], 4'h0} : {tx[6:0], 1'b0};
                    if (rd && clk_no + 5'h01 >= op_len) begin
                        link.host_io_oe <= 4'h0;
                    end
                end
                HS_HOLD: if (div_end) begin
                    link.cs_n       <= 1'b1;
                    link.host_io_oe <= 4'h0;
                end
                HS_GAP: begin
                end
            endcase
        end
    end

    // Read data sampled at the end of each high phase after the opcode
    always_ff @(posedge clock) begin
        if (reset) begin
            rx        <= 8'h00;
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
        end else begin
            rsp_valid <= 1'b0;
            if (state == HS_HIGH && div_end && rd && clk_no >= op_len) begin
                rx <= qpi ? {rx[3:0], io_s2} : {rx[6:0], io_s2[1]};
            end
            if (state == HS_HOLD && div_end && rd) begin
                rsp_valid <= 1'b1;
                rsp_data  <= rx;
            end
        end
    end

endmodule : fsp_host

`default_nettype wire

// ---- verilog/fsp_device.sv ----
// How it works
// - Exit opcode leaves secure area, SPI or QPI
// - Security read answered at any time
// - Read: opcode, then byte out until deselect
// - Host sends write enable before security write
// - Security write sets only lockdown bit
// - Deselect off byte boundary discards the command, except that security write and scheme select still clear write enable
// - Erase fail flag follows last erase result
// - Program fail flag follows last program result
// - Erase suspended flag tracks suspend and resume
// - Program suspended flag tracks suspend and resume
// - Bit 0 shows factory lock
// - Lockdown freezes itself and secure area
// - Secure area mode blocks main array
// - Security register bit layout and defaults
// - Scheme select picks exactly one protection scheme
// - Scheme select command sets select permanently
// - Block mode protects by block protect bits
// - Sector mode: dynamic bits preset, block bits ignored
// - Sector command group only in sector mode
// - Sector mode: write protect pin low protects all
// - Edge 4KB sectors, 64KB blocks, either bit protects
// - Solid bit changes need password in password mode
// - Protected target pages are not programmed
`timescale 1ns/1ps
`default_nettype none

module fsp_device
    import fsp_pkg::*;
#(
    parameter int ADDR_W = FSP_ADDR_W
) (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    reset,
    // Link
    fsp_link_if.dev                      link,
    // Mode and straps
    input  wire logic                    qpi_mode,
    input  wire logic                    factory_lock_strap,
    input  wire logic                    wp_n,
    // Engine events
    input  wire logic                    erase_done,
    input  wire logic                    erase_ok,
    input  wire logic                    program_done,
    input  wire logic                    program_ok,
    input  wire logic                    erase_suspend_taken,
    input  wire logic                    erase_resumed,
    input  wire logic                    program_suspend_taken,
    input  wire logic                    program_resumed,
    // Protection inputs for the current target
    input  wire logic [3:0]              block_protect_bits,
    input  wire logic                    bp_covers_target,
    input  wire logic [ADDR_W-1:0]       target_addr,
    input  wire logic                    target_solid,
    input  wire logic                    target_dynamic,
    input  wire logic                    password_mode,
    input  wire logic                    password_ok,
    // Status and protection outputs
    output logic [7:0]                   security_status_register,
    output logic                         write_enable_latch,
    output logic                         secure_area_mode,
    output logic                         main_array_blocked,
    output logic                         otp_update_allowed,
    output logic                         sector_cmds_enabled,
    output logic                         dynamic_preset,
    output logic [FSP_REGION_W-1:0]      target_region,
    output logic                         target_protected,
    output logic                         program_allowed,
    output logic                         erase_allowed,
    output logic                         solid_change_allowed
);

    logic       cs_s1, cs_s2, cs_d;
    logic       sck_s1, sck_s2, sck_d;
    logic [3:0] io_s1, io_s2;
    logic       wp_s1, wp_s2;
    logic       rise, fall, cs_rise;
    logic [4:0] op_len;
    logic [4:0] edge_cnt;
    logic [7:0] opcode;
    logic       exact;
    logic       reading;
    logic [2:0] out_pos;
    logic       scheme_select;
    logic       erase_fail, program_fail;
    logic       erase_susp, program_susp;
    logic       lockdown, factory_lock, strap_taken;
    logic       exec_ok;

    // Region index: 4KB sectors in lowest and highest 64KB, 64KB blocks between
    function automatic logic [FSP_REGION_W-1:0] region_of(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-FSP_BLOCK_LSB-1:0] blk;
        logic [3:0]                      sec;
        blk = addr[ADDR_W-1:FSP_BLOCK_LSB];
        sec = addr[FSP_BLOCK_LSB-1:FSP_SECTOR_LSB];
        if (blk == '0) begin
            region_of = FSP_REGION_W'(sec);
        end else if (blk == '1) begin
            region_of = FSP_REGION_W'(blk) + FSP_REGION_W'(FSP_SECTORS_EDGE - 1)
                      + FSP_REGION_W'(sec);
        end else begin
            region_of = FSP_REGION_W'(blk) + FSP_REGION_W'(FSP_SECTORS_EDGE - 1);
        end
    endfunction : region_of

    // Two-flop capture of link pins and write protect pin
    always_ff @(posedge clock) begin
        cs_s1  <= link.cs_n;
        cs_s2  <= cs_s1;
        cs_d   <= cs_s2;
        sck_s1 <= link.sclk;
        sck_s2 <= sck_s1;
        sck_d  <= sck_s2;
        io_s1  <= link.io;
        io_s2  <= io_s1;
        wp_s1  <= wp_n;
        wp_s2  <= wp_s1;
    end

    assign rise    = sck_s2 & ~sck_d & ~cs_s2;
    assign fall    = ~sck_s2 & sck_d & ~cs_s2;
    assign cs_rise = cs_s2 & ~cs_d;
    assign op_len  = qpi_mode ? FSP_QPI_CMD_CLOCKS : FSP_SPI_CMD_CLOCKS;
    assign exact   = (edge_cnt == op_len);
    assign reading = (edge_cnt >= op_len) && (opcode == FSP_READ_SECURITY_CMD);
    assign exec_ok = cs_rise && exact;

    // Rising edge count and opcode shift, 8 clocks on one line or 2 on four
    always_ff @(posedge clock) begin
        if (reset || cs_s2) begin
            edge_cnt <= 5'h00;
            opcode   <= 8'h00;
        end else if (rise) begin
            if (edge_cnt != FSP_EDGE_CNT_MAX) begin
                edge_cnt <= edge_cnt + 5'h01;
            end
            if (edge_cnt < op_len) begin
                opcode <= qpi_mode ? {opcode[3:0], io_s2} : {opcode[6:0], io_s2[0]};
            end
        end
    end

    // Register byte out from the first falling edge after the opcode until deselect
    always_ff @(posedge clock) begin
        if (reset || cs_s2) begin
            out_pos         <= FSP_SPI_FIRST_POS;
            link.dev_io_out <= 4'h0;
            link.dev_io_oe  <= 4'h0;
        end else if (fall && reading) begin
            if (qpi_mode) begin
                out_pos         <= (edge_cnt == op_len) ? (FSP_QPI_FIRST_POS ^ FSP_QPI_POS_TOGGLE)
                                                        : (out_pos ^ FSP_QPI_POS_TOGGLE);
                link.dev_io_out <= ((edge_cnt == op_len) || out_pos[2])
                                   ? security_status_register[7:4]
                                   : security_status_register[3:0];
                link.dev_io_oe  <= FSP_QPI_OE;
            end else begin
                out_pos         <= (edge_cnt == op_len) ? (FSP_SPI_FIRST_POS - 3'h1)
                                                        : (out_pos - 3'h1);
                link.dev_io_out <= {2'b00,
                                    security_status_register[(edge_cnt == op_len)
                                                             ? FSP_SPI_FIRST_POS : out_pos],
                                    1'b0};
                link.dev_io_oe  <= FSP_SPI_OUT_OE;
            end
        end
    end

    // Write enable latch
    always_ff @(posedge clock) begin
        if (reset) begin
            write_enable_latch <= 1'b0;
        end else if (cs_rise && opcode == FSP_WRITE_ENABLE_CMD && exact) begin
            write_enable_latch <= 1'b1;
        end else if (cs_rise && (opcode == FSP_WRITE_SECURITY_CMD
                                 || opcode == FSP_SCHEME_SELECT_CMD)) begin
            write_enable_latch <= 1'b0;
        end
    end

    // Secured area mode
    always_ff @(posedge clock) begin
        if (reset) begin
            secure_area_mode <= 1'b0;
        end else if (exec_ok && opcode == FSP_ENTER_SECURE_CMD) begin
            secure_area_mode <= 1'b1;
        end else if (exec_ok && opcode == FSP_EXIT_SECURE_CMD) begin
            secure_area_mode <= 1'b0;
        end
    end

    // One-time bits: customer lockdown and protection scheme select
    always_ff @(posedge clock) begin
        if (reset) begin
            lockdown      <= 1'b0;
            scheme_select <= 1'b0;
        end else if (exec_ok && write_enable_latch) begin
            if (opcode == FSP_WRITE_SECURITY_CMD && !lockdown) begin
                lockdown <= 1'b1;
            end
            if (opcode == FSP_SCHEME_SELECT_CMD) begin
                scheme_select <= 1'b1;
            end
        end
    end

    // Factory lock indicator caught once after reset release
    always_ff @(posedge clock) begin
        if (reset) begin
            factory_lock <= 1'b0;
            strap_taken  <= 1'b0;
        end else if (!strap_taken) begin
            factory_lock <= factory_lock_strap;
            strap_taken  <= 1'b1;
        end
    end

    // Fail flags follow the latest result and never stop the engine
    always_ff @(posedge clock) begin
        if (reset) begin
            erase_fail   <= 1'b0;
            program_fail <= 1'b0;
        end else begin
            if (erase_done) begin
                erase_fail <= ~erase_ok;
            end
            if (program_done) begin
                program_fail <= ~program_ok;
            end
        end
    end

    // Suspend flags, a suspend in the same cycle as a resume wins
    always_ff @(posedge clock) begin
        if (reset) begin
            erase_susp   <= 1'b0;
            program_susp <= 1'b0;
        end else begin
            if (erase_suspend_taken) begin
                erase_susp <= 1'b1;
            end else if (erase_resumed) begin
                erase_susp <= 1'b0;
            end
            if (program_suspend_taken) begin
                program_susp <= 1'b1;
            end else if (program_resumed) begin
                program_susp <= 1'b0;
            end
        end
    end

    // Register image
    always_comb begin
        security_status_register                         = FSP_SEC_RESET;
        security_status_register[FSP_SEC_SCHEME_BIT]     = scheme_select;
        security_status_register[FSP_SEC_ERASE_FAIL_BIT] = erase_fail;
        security_status_register[FSP_SEC_PROG_FAIL_BIT]  = program_fail;
        security_status_register[FSP_SEC_ERASE_SUSP_BIT] = erase_susp;
        security_status_register[FSP_SEC_PROG_SUSP_BIT]  = program_susp;
        security_status_register[FSP_SEC_LOCKDOWN_BIT]   = lockdown;
        security_status_register[FSP_SEC_FACTORY_BIT]    = factory_lock;
    end

    // Dynamic bits preset while reset is held
    always_ff @(posedge clock) begin
        dynamic_preset <= reset;
    end

    // Protection decisions for the current target
    always_ff @(posedge clock) begin
        if (reset) begin
            main_array_blocked   <= 1'b0;
            otp_update_allowed   <= 1'b0;
            sector_cmds_enabled  <= 1'b0;
            target_region        <= '0;
            target_protected     <= 1'b0;
            program_allowed      <= 1'b0;
            erase_allowed        <= 1'b0;
            solid_change_allowed <= 1'b0;
        end else begin
            main_array_blocked   <= secure_area_mode;
            otp_update_allowed   <= secure_area_mode && !lockdown;
            sector_cmds_enabled  <= scheme_select;
            target_region        <= region_of(target_addr);
            if (scheme_select) begin
                target_protected <= !wp_s2 || target_solid || target_dynamic;
            end else begin
                target_protected <= (|block_protect_bits) && bp_covers_target;
            end
            program_allowed      <= !secure_area_mode && !(scheme_select
                                    ? (!wp_s2 || target_solid || target_dynamic)
                                    : ((|block_protect_bits) && bp_covers_target));
            erase_allowed        <= !secure_area_mode && !(scheme_select
                                    ? (!wp_s2 || target_solid || target_dynamic)
                                    : ((|block_protect_bits) && bp_covers_target));
            solid_change_allowed <= scheme_select && (!password_mode || password_ok);
        end
    end

endmodule : fsp_device

`default_nettype wire

// ---- test/fsp_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module fsp_assertions
    import fsp_pkg::*;
(
    // Clock and reset
    input wire logic       clock,
    input wire logic       reset,
    // Link
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic [3:0] host_io_oe,
    input wire logic [3:0] dev_io_oe,
    // Device status
    input wire logic [7:0] security_status_register,
    input wire logic       write_enable_latch
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_deselected; cs_n [*5]; endsequence
    sequence s_wel_before; $past(write_enable_latch) || $past(write_enable_latch, 2); endsequence

    property p_dev_release; s_deselected |-> dev_io_oe == 4'h0; endproperty
    property p_no_contention; (host_io_oe & dev_io_oe) == 4'h0; endproperty
    property p_sclk_idle; cs_n |-> !sclk; endproperty
    property p_reserved; security_status_register[4] == 1'b0; endproperty
    property p_scheme_sticky; security_status_register[7] |=> security_status_register[7];
    endproperty
    property p_lock_sticky; security_status_register[1] |=> security_status_register[1];
    endproperty
    property p_lock_needs_wel; $rose(security_status_register[1]) |-> cs_n ##0 s_wel_before;
    endproperty
    property p_scheme_needs_wel; $rose(security_status_register[7]) |-> cs_n ##0 s_wel_before;
    endproperty

    a_dev_release: assert property (p_dev_release) else $error("device drives while idle");
    a_no_contention: assert property (p_no_contention) else $error("both ends drive");
    a_sclk_idle: assert property (p_sclk_idle) else $error("link clock high while idle");
    a_reserved: assert property (p_reserved) else $error("reserved bit set");
    a_scheme_sticky: assert property (p_scheme_sticky) else $error("scheme select cleared");
    a_lock_sticky: assert property (p_lock_sticky) else $error("lockdown cleared");
    a_lock_needs_wel: assert property (p_lock_needs_wel) else $error("lockdown without wel");
    a_scheme_needs_wel: assert property (p_scheme_needs_wel) else $error("scheme no wel");
endmodule : fsp_assertions

`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench
    import fsp_pkg::*;
;
    logic       clock = 1'b0;
    logic       reset = 1'b1;
    logic       q = 1'b0;
    logic       factory_lock_strap = 1'b1;
    logic       wp_n = 1'b1;
    logic       target_solid = 1'b0;
    logic       target_dynamic = 1'b1;
    logic [7:0] ev = 8'h00;
    logic [3:0] bp = 4'h0;
    logic       cmd_valid = 1'b0;
    logic [7:0] cmd_opcode = 8'h00;
    logic       cmd_read = 1'b0;
    logic [3:0] cmd_extra_clocks = 4'h0;
    logic       cmd_ready, rsp_valid, write_enable_latch;
    logic       main_array_blocked, sector_cmds_enabled, program_allowed, erase_allowed;
    logic [7:0] rsp_data, security_status_register;
    int         miscompares = 0;
    int         cmp_count = 0;
    int         cycles = 0;

    fsp_link_if link ();

    always #5 clock = ~clock;

    fsp_host #(.HALF_CYCLES(4)) fsp_host_i (.clock, .reset, .link(link.host), .cmd_valid,
        .cmd_opcode, .cmd_qpi(q), .cmd_read, .cmd_extra_clocks, .cmd_ready, .rsp_valid,
        .rsp_data);

    fsp_device fsp_device_i (.clock, .reset, .link(link.dev), .qpi_mode(q), .factory_lock_strap,
        .wp_n, .erase_done(ev[0]), .erase_ok(ev[1]), .program_done(ev[2]), .program_ok(ev[3]),
        .erase_suspend_taken(ev[4]), .erase_resumed(ev[5]), .program_suspend_taken(ev[6]),
        .program_resumed(ev[7]), .block_protect_bits(bp), .bp_covers_target(1'b1),
        .target_addr('0), .target_solid, .target_dynamic, .password_mode(1'b0),
        .password_ok(1'b0), .security_status_register, .write_enable_latch, .secure_area_mode(),
        .main_array_blocked, .otp_update_allowed(), .sector_cmds_enabled, .dynamic_preset(),
        .target_region(), .target_protected(), .program_allowed, .erase_allowed,
        .solid_change_allowed());

    fsp_assertions fsp_assertions_i (.clock, .reset, .cs_n(link.cs_n), .sclk(link.sclk),
        .host_io_oe(link.host_io_oe), .dev_io_oe(link.dev_io_oe), .security_status_register,
        .write_enable_latch);

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic xfer(input logic [7:0] op, input logic rd, input logic [3:0] ex,
                        input logic [7:0] exp);
        while (cmd_ready !== 1'b1) @(negedge clock);
        cmd_opcode = op;
        cmd_read = rd;
        cmd_extra_clocks = ex;
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
        while ((rd ? rsp_valid : cmd_ready) !== 1'b1) @(negedge clock);
        if (rd) chk("rsp_data", exp, rsp_data);
        repeat (8) @(negedge clock);
    endtask : xfer

    task automatic pulse(input logic [7:0] v);
        @(negedge clock);
        ev = v;
        @(negedge clock);
        ev = 8'h00;
        repeat (3) @(negedge clock);
    endtask : pulse

    task automatic final_report;
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        repeat (8) @(negedge clock);
        reset = 1'b0;
        xfer(FSP_READ_SECURITY_CMD, 1'b1, 4'h0, 8'h01);
        pulse(8'h05);
        pulse(8'h50);
        q = 1'b1;
        xfer(FSP_READ_SECURITY_CMD, 1'b1, 4'h0, 8'h6D);
        pulse(8'hAF);
        xfer(FSP_READ_SECURITY_CMD, 1'b1, 4'h0, 8'h01);
        xfer(FSP_WRITE_SECURITY_CMD, 1'b0, 4'h0, 8'h00);
        xfer(FSP_READ_SECURITY_CMD, 1'b1, 4'h0, 8'h01);
        xfer(FSP_WRITE_ENABLE_CMD, 1'b0, 4'h0, 8'h00);
        chk("write_enable_latch", 8'h01, {7'h00, write_enable_latch});
        xfer(FSP_WRITE_SECURITY_CMD, 1'b0, 4'h1, 8'h00);
        chk("write_enable_latch", 8'h00, {7'h00, write_enable_latch});
        xfer(FSP_READ_SECURITY_CMD, 1'b1, 4'h0, 8'h01);
        q = 1'b0;
        xfer(FSP_WRITE_ENABLE_CMD, 1'b0, 4'h0, 8'h00);
        xfer(FSP_WRITE_SECURITY_CMD, 1'b0, 4'h0, 8'h00);
        chk("write_enable_latch", 8'h00, {7'h00, write_enable_latch});
        xfer(FSP_READ_SECURITY_CMD, 1'b1, 4'h0, 8'h03);
        xfer(FSP_ENTER_SECURE_CMD, 1'b0, 4'h0, 8'h00);
        chk("main_array_blocked", 8'h01, {7'h00, main_array_blocked});
        q = 1'b1;
        xfer(FSP_EXIT_SECURE_CMD, 1'b0, 4'h0, 8'h00);
        chk("main_array_blocked", 8'h00, {7'h00, main_array_blocked});
        chk("sector_cmds_enabled", 8'h00, {7'h00, sector_cmds_enabled});
        chk("program_allowed", 8'h01, {7'h00, program_allowed});
        bp = 4'h3;
        repeat (4) @(negedge clock);
        chk("program_allowed", 8'h00, {7'h00, program_allowed});
        xfer(FSP_WRITE_ENABLE_CMD, 1'b0, 4'h0, 8'h00);
        xfer(FSP_SCHEME_SELECT_CMD, 1'b0, 4'h0, 8'h00);
        xfer(FSP_READ_SECURITY_CMD, 1'b1, 4'h0, 8'h83);
        chk("sector_cmds_enabled", 8'h01, {7'h00, sector_cmds_enabled});
        chk("program_allowed", 8'h00, {7'h00, program_allowed});
        target_dynamic = 1'b0;
        repeat (4) @(negedge clock);
        chk("program_allowed", 8'h01, {7'h00, program_allowed});
        wp_n = 1'b0;
        repeat (6) @(negedge clock);
        chk("program_allowed", 8'h00, {7'h00, program_allowed});
        chk("erase_allowed", 8'h00, {7'h00, erase_allowed});
        final_report();
    end
endmodule : testbench

`default_nettype wire
